// ===== dgc_pkg.sv
package dgc_pkg;

    // Register byte addresses
    localparam logic [3:0] DGC_OFS_UNLOCK = 4'h0;
    localparam logic [3:0] DGC_OFS_GENERAL = 4'h4;
    localparam logic [3:0] DGC_OFS_SPLIT = 4'h8;
    localparam logic [3:0] DGC_OFS_STATUS = 4'hC;

    // Values after reset
    localparam logic [31:0] DGC_RST_GENERAL = 32'h0000_0000;
    localparam logic [15:0] DGC_RST_UNLOCK = 16'h0000;
    localparam logic [10:0] DGC_RST_SPLIT = 11'h000;
    localparam logic [15:0] DGC_UNLOCK_CODE = 16'h4758;

    // Field positions of the general configuration register
    localparam int DGC_B_VIDEO_READY_PROTOCOL_SEL = 29;
    localparam int DGC_B_VIDEO_EN = 28;
    localparam int DGC_B_SPLIT_EN = 27;
    localparam int DGC_B_CHAIN4 = 26;
    localparam int DGC_B_FIFO_DIAGNOSTIC_MODE = 25;
    localparam int DGC_B_LINE_DOUBLING_EN = 24;
    localparam int DGC_B_FDIRTY = 18;
    localparam int DGC_B_INSERT = 16;
    localparam int DGC_B_STOP_HI = 15;
    localparam int DGC_B_STOP_LO = 12;
    localparam int DGC_B_BEGIN_HI = 11;
    localparam int DGC_B_BEGIN_LO = 8;
    localparam int DGC_B_DIV_HI = 7;
    localparam int DGC_B_DIV_LO = 6;
    localparam int DGC_B_DECMP = 5;
    localparam int DGC_B_CMP = 4;

    // Writable bits: 29:24, 18, 16, 15:4
    localparam logic [31:0] DGC_GEN_WMASK = 32'h3F05_FFF0;

    // Dot clock divider encodings
    localparam logic [1:0] DGC_DIV_LOW = 2'h0;
    localparam logic [1:0] DGC_DIV_HALF = 2'h1;

    // Display geometry
    localparam int DGC_LINE_W = 11;
    localparam int DGC_FIFO_W = 6;
    localparam int DGC_DIRTY_LINES = 2048;
    localparam logic [1:0] DGC_CHAIN4_PHASE = 2'h0;

    typedef enum logic [1:0] {
        DGC_FR_UPDATE = 2'b00,
        DGC_FR_STATIC = 2'b01
    } dgc_frame_t;

endpackage

// ===== dgc_dirty_mem.sv
`timescale 1ns/1ps
module dgc_dirty_mem
    import dgc_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Set side
    input wire logic set_line_en,
    input wire logic [DGC_LINE_W-1:0] set_line,
    input wire logic set_all,
    // Clear and query side
    input wire logic clr_en,
    input wire logic [DGC_LINE_W-1:0] rd_line,
    output logic rd_dirty
);

    logic [DGC_DIRTY_LINES-1:0] flag_q;
    logic rd_dirty_q;

    // One flag per line; set wins over clear
    genvar gi;
    generate
        for (gi = 0; gi < DGC_DIRTY_LINES; gi++) begin : g_flag
            wire logic set_w = set_all || (set_line_en && set_line == DGC_LINE_W'(gi));
            wire logic clr_w = clr_en && rd_line == DGC_LINE_W'(gi);
            always_ff @(posedge clk_sys or posedge sys_rst) begin
                if (sys_rst) begin
                    flag_q[gi] <= 1'b0;
                end else if (set_w) begin
                    flag_q[gi] <= 1'b1;
                end else if (clr_w) begin
                    flag_q[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            rd_dirty_q <= 1'b0;
        end else begin
            rd_dirty_q <= flag_q[rd_line];
        end
    end

    assign rd_dirty = rd_dirty_q;

endmodule // dgc_dirty_mem

// ===== dgc_dot_clock.sv
`timescale 1ns/1ps
module dgc_dot_clock
    import dgc_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Synchronised dot clock level and divider
    input wire logic dot_level,
    input wire logic [1:0] divider,
    // Output dot clock, registered
    output logic dot_clk_out
);

    logic prev_q;
    logic half_q;
    logic out_q;
    wire logic rise_w = dot_level && !prev_q;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            prev_q <= 1'b0;
            half_q <= 1'b0;
            out_q <= 1'b0;
        end else begin
            prev_q <= dot_level;
            half_q <= rise_w ? !half_q : half_q;
            unique case (divider)
                DGC_DIV_LOW: out_q <= 1'b0;
                DGC_DIV_HALF: out_q <= rise_w ? !half_q : half_q;
                default: out_q <= dot_level;
            endcase
        end
    end

    assign dot_clk_out = out_q;

endmodule // dgc_dot_clock

// ===== dgc_general_cfg.sv
// Summary of operation
// - Motion video port enabled exactly while bit 28 is one.
// - Split compare on: matching line counter switches fetch to lower screen base.
// - Chain-4 skip on: fetch only every fourth doubleword.
// - Rising edge of bit 25 resets display FIFO and line buffer pointers.
// - Line doubling on: each odd line repeats the preceding line.
// - Frame dirty mode on: any frame buffer write marks the whole frame dirty.
// - Frame dirty mode off: only the written pixel's line becomes dirty.
// - Insert mode on: one static frame between successive update frames.
// - End high-priority request once FIFO depth/4 reaches the end level.
// - Raise high-priority request when FIFO depth/4 falls to the start level.
// - Divider 00 forces low, 01 halves, 10 and 11 pass dot clock.
// - Decompressor runs only while bit 5 is one.
// - Compressor runs only while bit 4 is one.
// - General register writes take effect only while unlock register holds the code.
`timescale 1ns/1ps
module dgc_general_cfg
    import dgc_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Display timing inputs, same clock
    input wire logic [DGC_LINE_W-1:0] line_count,
    input wire logic frame_start,
    input wire logic [DGC_FIFO_W-1:0] fifo_depth,
    input wire logic dword_fetch,
    input wire logic [1:0] dword_phase,
    // Frame buffer writes
    input wire logic fb_write,
    input wire logic [DGC_LINE_W-1:0] fb_write_line,
    input wire logic dirty_clear,
    // Dot clock pin
    input wire logic dot_clock_input,
    // Controls to the display path
    output logic motion_video_port_en,
    output logic video_ready_protocol_sel,
    output logic lower_screen_sel,
    output logic fetch_keep,
    output logic fifo_ptr_reset,
    output logic line_repeat,
    output logic frame_is_static,
    output logic line_dirty,
    output logic mem_hi_pri_req,
    output logic dot_clk_out,
    output logic decompressor_en,
    output logic compressor_en
);

    // Register state
    logic [31:0] general_q;
    logic [15:0] unlock_q;
    logic [DGC_LINE_W-1:0] split_q;
    logic [31:0] rdata_q;
    logic ack_q;
    logic wait_q;
    logic fifo_diagnostic_mode_prev_q;
    logic ptr_rst_q;
    logic lower_q;
    logic keep_q;
    logic repeat_q;
    logic hipri_q;
    dgc_frame_t frame_q;
    logic [2:0] dot_sync_q;
    logic dot_level_q;
    logic video_q;
    logic video_ready_protocol_sel_q;
    logic decmp_q;
    logic cmp_q;

    // Bus decode
    wire logic req_w = (avs_read || avs_write) && !ack_q;
    wire logic wr_w = avs_write && ack_q;
    wire logic hit_unlock_w = avs_address == DGC_OFS_UNLOCK;
    wire logic hit_general_w = avs_address == DGC_OFS_GENERAL;
    wire logic hit_split_w = avs_address == DGC_OFS_SPLIT;
    wire logic hit_status_w = avs_address == DGC_OFS_STATUS;
    wire logic [31:0] bmask_w = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                                 {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    wire logic unlocked_w = unlock_q == DGC_UNLOCK_CODE;
    wire logic gen_we_w = wr_w && hit_general_w && unlocked_w;
    wire logic [31:0] gen_m_w = bmask_w & DGC_GEN_WMASK;
    wire logic [31:0] gen_d_w = (general_q & ~gen_m_w) | (avs_writedata & gen_m_w);
    wire logic [31:0] status_w = {24'h00_0000, hipri_q, repeat_q, lower_q,
                                  frame_q == DGC_FR_STATIC, 3'h0, unlocked_w};
    wire logic [31:0] rd_mux_w =
        hit_unlock_w ? {16'h0000, unlock_q} :
        hit_general_w ? general_q :
        hit_split_w ? {{(32-DGC_LINE_W){1'b0}}, split_q} :
        hit_status_w ? status_w : 32'h0000_0000;

    // Field extraction
    wire logic [3:0] stop_lvl_w = general_q[DGC_B_STOP_HI:DGC_B_STOP_LO];
    wire logic [3:0] begin_lvl_w = general_q[DGC_B_BEGIN_HI:DGC_B_BEGIN_LO];
    wire logic [3:0] depth4_w = fifo_depth[DGC_FIFO_W-1:2];
    wire logic fifo_diagnostic_mode_w = general_q[DGC_B_FIFO_DIAGNOSTIC_MODE];
    wire logic dot_stable_w = dot_sync_q[1] == dot_sync_q[2];

    // Register writes
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            general_q <= DGC_RST_GENERAL;
            unlock_q <= DGC_RST_UNLOCK;
            split_q <= DGC_RST_SPLIT;
        end else begin
            if (wr_w && hit_unlock_w) begin
                unlock_q <= (unlock_q & ~bmask_w[15:0]) | (avs_writedata[15:0] & bmask_w[15:0]);
            end
            if (gen_we_w) begin
                general_q <= gen_d_w;
            end
            if (wr_w && hit_split_w) begin
                split_q <= (split_q & ~bmask_w[DGC_LINE_W-1:0])
                         | (avs_writedata[DGC_LINE_W-1:0] & bmask_w[DGC_LINE_W-1:0]);
            end
        end
    end

    // Bus answer: one wait cycle, then ack; writes land in the ack cycle
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ack_q <= 1'b0;
            wait_q <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q <= req_w;
            wait_q <= !req_w;
            rdata_q <= (avs_read && req_w) ? rd_mux_w : rdata_q;
        end
    end

    // FIFO pointer reset on rising diagnostic bit
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            fifo_diagnostic_mode_prev_q <= 1'b0;
            ptr_rst_q <= 1'b0;
        end else begin
            fifo_diagnostic_mode_prev_q <= fifo_diagnostic_mode_w;
            ptr_rst_q <= fifo_diagnostic_mode_w && !fifo_diagnostic_mode_prev_q;
        end
    end

    // Split screen, chain-4 skip, line doubling
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            lower_q <= 1'b0;
            keep_q <= 1'b0;
            repeat_q <= 1'b0;
        end else begin
            if (frame_start || !general_q[DGC_B_SPLIT_EN]) begin
                lower_q <= 1'b0;
            end else if (line_count == split_q) begin
                lower_q <= 1'b1;
            end
            keep_q <= dword_fetch && (!general_q[DGC_B_CHAIN4]
                      || dword_phase == DGC_CHAIN4_PHASE);
            repeat_q <= general_q[DGC_B_LINE_DOUBLING_EN] && line_count[0];
        end
    end

    // High-priority memory request hysteresis
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            hipri_q <= 1'b0;
        end else if (hipri_q && depth4_w >= stop_lvl_w) begin
            hipri_q <= 1'b0;
        end else if (!hipri_q && depth4_w <= begin_lvl_w) begin
            hipri_q <= 1'b1;
        end
    end

    // Update and static frame alternation
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            frame_q <= DGC_FR_UPDATE;
        end else if (frame_start) begin
            unique case (frame_q)
                DGC_FR_UPDATE: frame_q <= general_q[DGC_B_INSERT]
                                          ? DGC_FR_STATIC : DGC_FR_UPDATE;
                DGC_FR_STATIC: frame_q <= DGC_FR_UPDATE;
                default: frame_q <= DGC_FR_UPDATE;
            endcase
        end
    end

    // Dot clock pin synchroniser and enables
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            dot_sync_q <= 3'h0;
            dot_level_q <= 1'b0;
            video_q <= 1'b0;
            video_ready_protocol_sel_q <= 1'b0;
            decmp_q <= 1'b0;
            cmp_q <= 1'b0;
        end else begin
            dot_sync_q <= {dot_sync_q[1:0], dot_clock_input};
            dot_level_q <= dot_stable_w ? dot_sync_q[2] : dot_level_q;
            video_q <= general_q[DGC_B_VIDEO_EN];
            video_ready_protocol_sel_q <= general_q[DGC_B_VIDEO_READY_PROTOCOL_SEL];
            decmp_q <= general_q[DGC_B_DECMP];
            cmp_q <= general_q[DGC_B_CMP];
        end
    end

    // Line dirty flags
    dgc_dirty_mem u_dirty (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .set_line_en(fb_write && !general_q[DGC_B_FDIRTY]),
        .set_line(fb_write_line),
        .set_all(fb_write && general_q[DGC_B_FDIRTY]),
        .clr_en(dirty_clear && frame_q == DGC_FR_UPDATE),
        .rd_line(line_count),
        .rd_dirty(line_dirty)
    );

    // Dot clock divider
    dgc_dot_clock u_dot (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .dot_level(dot_level_q),
        .divider(general_q[DGC_B_DIV_HI:DGC_B_DIV_LO]),
        .dot_clk_out(dot_clk_out)
    );

    // are kept by software; the levels are used as written
    assign avs_readdata = rdata_q;
    assign avs_waitrequest = wait_q;
    assign motion_video_port_en = video_q;
    assign video_ready_protocol_sel = video_ready_protocol_sel_q;
    assign lower_screen_sel = lower_q;
    assign fetch_keep = keep_q;
    assign fifo_ptr_reset = ptr_rst_q;
    assign line_repeat = repeat_q;
    // Static frame is the only state code with bit 0 set
    assign frame_is_static = frame_q[0];
    assign mem_hi_pri_req = hipri_q;
    assign decompressor_en = decmp_q;
    assign compressor_en = cmp_q;

endmodule // dgc_general_cfg

// ===== dgc_general_cfg_checker.sv
`timescale 1ns/1ps
module dgc_general_cfg_checker
    import dgc_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Watched ports
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic [DGC_LINE_W-1:0] line_count,
    input wire logic frame_start,
    input wire logic [DGC_FIFO_W-1:0] fifo_depth,
    input wire logic dword_fetch,
    input wire logic [1:0] dword_phase,
    input wire logic fetch_keep,
    input wire logic fifo_ptr_reset,
    input wire logic line_repeat,
    input wire logic frame_is_static,
    input wire logic mem_hi_pri_req
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);
    chk_bus_one_wait: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("Bus request not answered after one wait cycle");
    chk_bus_ack_single: assert property (
        !avs_waitrequest |=> avs_waitrequest)
        else $error("Bus answer longer than one cycle");
    chk_fetch_idle: assert property (
        !dword_fetch |=> !fetch_keep)
        else $error("Fetch kept without a fetch");
    chk_fetch_phase_zero: assert property (
        dword_fetch && dword_phase == 2'h0 |=> fetch_keep)
        else $error("Phase zero fetch dropped");
    chk_repeat_even_line: assert property (
        !line_count[0] |=> !line_repeat)
        else $error("Even line marked as repeated");
    chk_ptr_reset_pulse: assert property (
        fifo_ptr_reset |=> !fifo_ptr_reset)
        else $error("Pointer reset longer than one cycle");
    chk_frame_change_cause: assert property (
        !$stable(frame_is_static) |-> $past(frame_start))
        else $error("Frame kind changed without frame start");
    chk_hi_pri_full: assert property (
        fifo_depth[5:2] == 4'hF |=> !mem_hi_pri_req)
        else $error("Priority request kept with full fifo");
endmodule // dgc_general_cfg_checker

// ===== dgc_mem_model.sv
`timescale 1ns/1ps
module dgc_mem_model
    import dgc_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Control and request
    input wire logic run,
    input wire logic mem_hi_pri_req,
    // Fifo fill seen by the display side
    output logic [DGC_FIFO_W-1:0] fifo_depth
);
    // Display drains one entry a cycle; a priority request refills three
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            fifo_depth <= 6'h20;
        end else if (run && mem_hi_pri_req && fifo_depth <= 6'h3C) begin
            fifo_depth <= fifo_depth + 6'h3;
        end else if (run && !mem_hi_pri_req && fifo_depth != 6'h0) begin
            fifo_depth <= fifo_depth - 6'h1;
        end
    end
endmodule // dgc_mem_model

// ===== testbench.sv
`timescale 1ns/1ps
module testbench
    import dgc_pkg::*;
;
    localparam logic [31:0] GB = 32'h2000_2100;
    logic clk_sys, sys_rst, avs_read, avs_write, avs_waitrequest, frame_start, dword_fetch;
    logic fb_write, dot_clock_input, mm_run, fetch_keep, fifo_ptr_reset, line_repeat, dirty_clear;
    logic motion_video_port_en, video_ready_protocol_sel, lower_screen_sel, frame_is_static;
    logic line_dirty, mem_hi_pri_req, dot_clk_out, decompressor_en, compressor_en;
    logic [3:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [DGC_LINE_W-1:0] line_count, fb_write_line;
    logic [DGC_FIFO_W-1:0] fifo_depth;
    logic [1:0] dword_phase;
    int num_errors, num_checks;
    wire [3:0] en_vec = {motion_video_port_en, video_ready_protocol_sel, decompressor_en,
        compressor_en};
    wire [2:0] ln_vec = {lower_screen_sel, line_repeat, line_dirty};
    dgc_general_cfg i_dut (.clk_sys, .sys_rst, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .line_count,
        .frame_start, .fifo_depth, .dword_fetch, .dword_phase, .fb_write, .fb_write_line,
        .dirty_clear, .dot_clock_input, .motion_video_port_en, .video_ready_protocol_sel,
        .lower_screen_sel, .fetch_keep, .fifo_ptr_reset, .line_repeat, .frame_is_static,
        .line_dirty, .mem_hi_pri_req, .dot_clk_out, .decompressor_en, .compressor_en);
    dgc_mem_model i_mem (.clk_sys, .sys_rst, .run(mm_run), .mem_hi_pri_req, .fifo_depth);
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = !clk_sys;
    end
    always begin
        repeat (7) @(posedge clk_sys);
        dot_clock_input <= !dot_clock_input;
    end
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge clk_sys);
        avs_read <= !w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= d;
        do begin
            @(posedge clk_sys);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rdc(input string nm, input logic [3:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(nm, e, q);
    endtask
    task automatic look(input int n);
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask
    task automatic ln(input int v, input logic [2:0] e);
        @(posedge clk_sys);
        line_count <= DGC_LINE_W'(v);
        look(2);
        check("line_flags", {29'h0, e}, {29'h0, ln_vec});
    endtask
    task automatic frm(input logic e);
        @(posedge clk_sys);
        frame_start <= 1'b1;
        @(posedge clk_sys);
        frame_start <= 1'b0;
        look(0);
        check("frame_static", {31'h0, e}, {31'h0, frame_is_static});
    endtask
    task automatic fetch(input logic [1:0] ph, input logic e);
        @(posedge clk_sys);
        dword_fetch <= 1'b1;
        dword_phase <= ph;
        @(posedge clk_sys);
        dword_fetch <= 1'b0;
        look(0);
        check("fetch_keep", {31'h0, e}, {31'h0, fetch_keep});
    endtask
    task automatic fbw(input int v);
        @(posedge clk_sys);
        fb_write <= 1'b1;
        fb_write_line <= DGC_LINE_W'(v);
        @(posedge clk_sys);
        fb_write <= 1'b0;
    endtask
    task automatic clr(input int v);
        @(posedge clk_sys);
        line_count <= DGC_LINE_W'(v);
        dirty_clear <= 1'b1;
        @(posedge clk_sys);
        dirty_clear <= 1'b0;
    endtask
    task automatic pulses(output int c);
        c = 0;
        repeat (6) begin
            @(negedge clk_sys);
            c += int'(fifo_ptr_reset === 1'b1);
        end
    endtask
    task automatic t_regs;
        rdc("general", 4'h4, DGC_RST_GENERAL);
        wr(4'h4, 32'hFFFF_FFFF);
        rdc("locked", 4'h4, 32'h0);
        rdc("unmapped", 4'h2, 32'h0);
        wr(4'h0, {16'h0, DGC_UNLOCK_CODE});
        wr(4'h4, 32'hFFFF_FEFF);
        rdc("unlocked", 4'h4, DGC_GEN_WMASK & 32'hFFFF_FEFF);
        wr(4'h8, 32'h5);
        rdc("split", 4'h8, 32'h5);
        rdc("status", 4'hC, 32'h0000_00A1);
        $display("Test regs done");
    endtask
    task automatic t_ctrl;
        int c;
        wr(4'h4, GB | 32'h1000_0030);
        look(2);
        check("enables", 32'hF, en_vec);
        wr(4'h4, GB | 32'h0200_0000);
        pulses(c);
        check("enables_off", 32'h4, en_vec);
        check("ptr_reset", 32'h1, c);
        wr(4'h4, GB | 32'h0200_0000);
        pulses(c);
        check("ptr_reset_held", 32'h0, c);
        $display("Test ctrl done");
    endtask
    task automatic t_chain;
        wr(4'h4, GB | 32'h0400_0000);
        fetch(2'h1, 1'b0);
        fetch(2'h0, 1'b1);
        wr(4'h4, GB);
        fetch(2'h1, 1'b1);
        $display("Test chain done");
    endtask
    task automatic t_lines;
        wr(4'h4, GB | 32'h0900_0000);
        ln(3, 3'b010);
        ln(4, 3'b000);
        ln(5, 3'b110);
        ln(6, 3'b100);
        frm(1'b0);
        check("split_clear", 32'h0, ln_vec);
        wr(4'h4, GB);
        ln(3, 3'b000);
        $display("Test lines done");
    endtask
    task automatic t_dirty;
        fbw(3);
        ln(3, 3'b001);
        ln(4, 3'b000);
        wr(4'h4, GB | 32'h0004_0000);
        fbw(9);
        ln(4, 3'b001);
        ln(700, 3'b001);
        $display("Test dirty done");
    endtask
    task automatic t_insert;
        wr(4'h4, GB | 32'h0001_0000);
        frm(1'b1);
        clr(700);
        ln(700, 3'b001);
        frm(1'b0);
        clr(700);
        ln(700, 3'b000);
        frm(1'b1);
        wr(4'h4, GB);
        frm(1'b0);
        frm(1'b0);
        $display("Test insert done");
    endtask
    task automatic t_dot;
        int c, e;
        logic p;
        for (int dv = 0; dv < 4; dv++) begin
            wr(4'h4, GB | (32'(dv) << 6));
            look(10);
            c = 0;
            p = dot_clk_out;
            repeat (140) begin
                @(negedge clk_sys);
                c += int'(dot_clk_out && !p);
                p = dot_clk_out;
            end
            e = (dv == 0) ? 0 : ((dv == 1) ? 5 : 10);
            check("dot_rises", 32'h1,
                {31'h0, (dv == 0) ? c == 0 : (c >= e - 1 && c <= e + 1)});
        end
        $display("Test dot done");
    endtask
    task automatic t_prio(input logic [3:0] b, input logic [3:0] e);
        logic r, ex;
        logic [3:0] d;
        int rises;
        rises = 0;
        wr(4'h4, 32'h2000_0000 | {16'h0, e, b, 8'h0});
        mm_run <= 1'b1;
        @(negedge clk_sys);
        r = mem_hi_pri_req;
        d = fifo_depth[5:2];
        repeat (300) begin
            @(negedge clk_sys);
            ex = (d >= e) ? 1'b0 : ((d <= b) ? 1'b1 : r);
            check("hi_pri_req", {31'h0, ex}, {31'h0, mem_hi_pri_req});
            rises += int'(!r && mem_hi_pri_req);
            r = mem_hi_pri_req;
            d = fifo_depth[5:2];
        end
        check("hi_pri_raised", 32'h1, {31'h0, rises > 0});
        @(posedge clk_sys);
        mm_run <= 1'b0;
        $display("Test prio done");
    endtask
    task automatic end_of_test;
        $display("Checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        num_errors = 0;
        num_checks = 0;
        sys_rst = 1'b1;
        {avs_read, avs_write, frame_start, dword_fetch, fb_write, dot_clock_input, mm_run} = '0;
        {avs_address, avs_writedata, line_count, fb_write_line, dword_phase, dirty_clear} = '0;
        repeat (16) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_regs();
        t_ctrl();
        t_chain();
        t_lines();
        t_dirty();
        t_insert();
        t_dot();
        t_prio(4'h2, 4'h6);
        t_prio(4'hE, 4'hF);
        end_of_test();
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        num_errors++;
        end_of_test();
    end
endmodule // testbench
bind dgc_general_cfg dgc_general_cfg_checker i_chk (.clk_sys, .sys_rst, .avs_read, .avs_write,
    .avs_waitrequest, .line_count, .frame_start, .fifo_depth, .dword_fetch, .dword_phase,
    .fetch_keep, .fifo_ptr_reset, .line_repeat, .frame_is_static, .mem_hi_pri_req);
